/* File: rtl/scd_pkg.sv */
// package: strap decoder register map, field positions and encodings
package scd_pkg;
  // coined register indices on the plain register port
  localparam logic [3:0] ADDR_ADV      = 4'h0; // advertisement word (reg 4)
  localparam logic [3:0] ADDR_GIG      = 4'h1; // gigabit control (reg 9)
  localparam logic [3:0] ADDR_AUX_EN   = 4'h2; // reg 18
  localparam logic [3:0] ADDR_EXT_CTL  = 4'h3; // reg 20E
  localparam logic [3:0] ADDR_MAC_CTL  = 4'h4; // reg 23
  localparam logic [3:0] ADDR_PWR_CTL  = 4'h5; // reg 28
  localparam logic [3:0] ADDR_STRAP    = 4'h6; // raw sampled strap bits
  localparam logic [3:0] ADDR_STATUS   = 4'h7; // load done, reserved misuse

  // field positions
  localparam int ADV_ABIL_LO   = 5;   // reg 4 bits 8:5
  localparam int ADV_SYM_PAUSE = 10;
  localparam int ADV_ASY_PAUSE = 11;
  localparam int GIG_ABIL_LO   = 8;   // reg 9 bits 9:8
  localparam int AUX_EN_BIT    = 0;
  localparam int DOWNSHIFT_BIT = 4;
  localparam int AUX_FREQ_BIT  = 8;
  localparam int MEDIA_LO      = 8;   // reg 23 bits 10:8
  localparam int MAC_ANEG_BIT  = 13;
  localparam int LDPS_BIT      = 6;

  // speed/duplex strap codes -> {reg4[8:5]} and {reg9[9:8]}
  // reg4 8:5 = 100FD,100HD,10FD,10HD ; reg9 9:8 = 1000FD,1000HD
  localparam logic [3:0] ADV_ALL    = 4'hF;
  localparam logic [1:0] GIG_ALL    = 2'h3;
  localparam logic [3:0] ADV_NOHALF = 4'hF;
  localparam logic [1:0] GIG_FDX    = 2'h2;
  localparam logic [3:0] ADV_NONE   = 4'h0;
  localparam logic [1:0] GIG_NONE   = 2'h0;

  localparam logic [2:0] MEDIA_RSVD = 3'h4;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : scd_pkg

/* File: rtl/scd_sync.sv */
// module: two-flop synchroniser for a bus of strap pin levels
`timescale 1ns/1ns
`default_nettype none
module scd_sync #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : scd_sync
`default_nettype wire

/* File: rtl/scd_strap_decoder.sv */
// module: strap pin sampler and register default loader
// Behaviour
// - pin 7 bit 2 loads downshift enable, reg 20E bit 4
// - pin 7 bits 1:0 set advertised abilities; 00 all, 01 no 1000 half
// - speed code 10 gives 1000 full only; 11 gives 10/100 both duplexes
// - pin 6 bits load MAC aneg, power saving, asym and sym pause
// - media codes 010, 011 select fiber modes; 100 is reserved
// - media codes 101 and 111 select copper/fiber auto sensing
// - media code 110 selects copper or 1000BASE-X auto sensing
// - pin 5 bit 1 selects aux clock 125 or 156.25 MHz
// - pin 5 bit 0 loads aux clock output enable, reg 18 bit 0
// - each of eight strap pins gives four configuration bits
`timescale 1ns/1ns
`default_nettype none
module scd_strap_decoder #(
  parameter int NPINS = 8,
  parameter int BITS  = 4
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [NPINS*BITS-1:0] config_strap_pins_i,
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [15:0]           reg_rdata_o,
  output logic                       load_done_o,
  output logic      [2:0]            media_sel_o,
  output logic                       aux_clock_output_en_o,
  output logic                       aux_clock_output_fast_o,
  output logic                       downshift_en_o,
  output logic                       mac_aneg_en_o,
  output logic                       link_down_power_saving_o
);
  typedef enum logic [1:0] {SCD_SETTLE, SCD_FILL, SCD_LOAD, SCD_RUN}
    scd_state_e;

  logic [NPINS*BITS-1:0] strap_sync;
  logic [NPINS*BITS-1:0] strap_cap;
  scd_state_e            state;
  logic [15:0] reg_adv, reg_gig, reg_aux, reg_ext, reg_mac, reg_pwr;
  logic        rsvd_misuse;

  // each pin carries four bits: pin p bit b sits at p*BITS+b
  function automatic logic strap_bit(input logic [NPINS*BITS-1:0] s,
                                     input int p, input int b);
    strap_bit = s[p*BITS+b];
  endfunction : strap_bit

  // speed/duplex strap to advertisement fields
  function automatic logic [5:0] speed_adv(input logic [1:0] code);
    case (code)
      2'b00:   speed_adv = {scd_pkg::GIG_ALL, scd_pkg::ADV_ALL};
      2'b01:   speed_adv = {scd_pkg::GIG_FDX, scd_pkg::ADV_NOHALF};
      2'b10:   speed_adv = {scd_pkg::GIG_FDX, scd_pkg::ADV_NONE};
      default: speed_adv = {scd_pkg::GIG_NONE, scd_pkg::ADV_ALL};
    endcase
  endfunction : speed_adv

  scd_sync #(.W(NPINS*BITS)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (config_strap_pins_i),
    .sync_o    (strap_sync)
  );

  logic       ld;
  logic [1:0] spd;
  logic [2:0] media;
  logic [5:0] abil;
  assign ld    = (state == SCD_LOAD);
  assign spd   = {strap_bit(strap_sync, 7, 1), strap_bit(strap_sync, 7, 0)};
  assign abil  = speed_adv(spd);
  assign media = {strap_bit(strap_sync, 5, 3), strap_bit(strap_sync, 4, 3),
                  strap_bit(strap_sync, 3, 3)};

  // two settle cycles: both sync flops must hold pin levels before the load
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= SCD_SETTLE;
    end else begin
      case (state)
        SCD_SETTLE: state <= SCD_FILL;
        SCD_FILL:   state <= SCD_LOAD;
        SCD_LOAD:   state <= SCD_RUN;
        SCD_RUN:    state <= SCD_RUN;
        default:    state <= SCD_SETTLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_cap   <= '0;
      rsvd_misuse <= 1'b0;
    end else if (ld) begin
      strap_cap   <= strap_sync;
      // board must tie these low; flag if not, ignore their value
      rsvd_misuse <= strap_bit(strap_sync, 7, 3) |
                     strap_bit(strap_sync, 5, 2) |
                     (media == scd_pkg::MEDIA_RSVD);
    end
  end

  logic wr_adv, wr_gig, wr_aux, wr_ext, wr_mac, wr_pwr;
  assign wr_adv = reg_wr_i && reg_addr_i == scd_pkg::ADDR_ADV;
  assign wr_gig = reg_wr_i && reg_addr_i == scd_pkg::ADDR_GIG;
  assign wr_aux = reg_wr_i && reg_addr_i == scd_pkg::ADDR_AUX_EN;
  assign wr_ext = reg_wr_i && reg_addr_i == scd_pkg::ADDR_EXT_CTL;
  assign wr_mac = reg_wr_i && reg_addr_i == scd_pkg::ADDR_MAC_CTL;
  assign wr_pwr = reg_wr_i && reg_addr_i == scd_pkg::ADDR_PWR_CTL;

  // strap load happens once; software writes take effect afterwards
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_adv <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_adv <= scd_pkg::REG_RESET;
      reg_adv[scd_pkg::ADV_ABIL_LO +: 4] <= abil[3:0];
      reg_adv[scd_pkg::ADV_ASY_PAUSE] <= strap_bit(strap_sync, 6, 1);
      reg_adv[scd_pkg::ADV_SYM_PAUSE] <= strap_bit(strap_sync, 6, 0);
    end else if (wr_adv) begin
      reg_adv <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_gig <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_gig <= scd_pkg::REG_RESET;
      reg_gig[scd_pkg::GIG_ABIL_LO +: 2] <= abil[5:4];
    end else if (wr_gig) begin
      reg_gig <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_aux <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_aux <= scd_pkg::REG_RESET;
      reg_aux[scd_pkg::AUX_EN_BIT] <= strap_bit(strap_sync, 5, 0);
    end else if (wr_aux) begin
      reg_aux <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_ext <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_ext <= scd_pkg::REG_RESET;
      reg_ext[scd_pkg::DOWNSHIFT_BIT] <= strap_bit(strap_sync, 7, 2);
      reg_ext[scd_pkg::AUX_FREQ_BIT] <= strap_bit(strap_sync, 5, 1);
    end else if (wr_ext) begin
      reg_ext <= reg_wdata_i;
    end
  end

  // media codes pass straight through; 100 is reserved and kept as strapped
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_mac <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_mac <= scd_pkg::REG_RESET;
      reg_mac[scd_pkg::MEDIA_LO +: 3] <= media;
      reg_mac[scd_pkg::MAC_ANEG_BIT] <= strap_bit(strap_sync, 6, 3);
    end else if (wr_mac) begin
      reg_mac <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_pwr <= scd_pkg::REG_RESET;
    end else if (ld) begin
      reg_pwr <= scd_pkg::REG_RESET;
      reg_pwr[scd_pkg::LDPS_BIT] <= strap_bit(strap_sync, 6, 2);
    end else if (wr_pwr) begin
      reg_pwr <= reg_wdata_i;
    end
  end

  // register-fed outputs, one cycle behind the fields
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_done_o              <= 1'b0;
      media_sel_o              <= 3'h0;
      aux_clock_output_en_o    <= 1'b0;
      aux_clock_output_fast_o  <= 1'b0;
      downshift_en_o           <= 1'b0;
      mac_aneg_en_o            <= 1'b0;
      link_down_power_saving_o <= 1'b0;
    end else begin
      load_done_o              <= (state == SCD_RUN);
      media_sel_o              <= reg_mac[scd_pkg::MEDIA_LO +: 3];
      aux_clock_output_en_o    <= reg_aux[scd_pkg::AUX_EN_BIT];
      aux_clock_output_fast_o  <= reg_ext[scd_pkg::AUX_FREQ_BIT];
      downshift_en_o           <= reg_ext[scd_pkg::DOWNSHIFT_BIT];
      mac_aneg_en_o            <= reg_mac[scd_pkg::MAC_ANEG_BIT];
      link_down_power_saving_o <= reg_pwr[scd_pkg::LDPS_BIT];
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        scd_pkg::ADDR_ADV:     reg_rdata_o <= reg_adv;
        scd_pkg::ADDR_GIG:     reg_rdata_o <= reg_gig;
        scd_pkg::ADDR_AUX_EN:  reg_rdata_o <= reg_aux;
        scd_pkg::ADDR_EXT_CTL: reg_rdata_o <= reg_ext;
        scd_pkg::ADDR_MAC_CTL: reg_rdata_o <= reg_mac;
        scd_pkg::ADDR_PWR_CTL: reg_rdata_o <= reg_pwr;
        scd_pkg::ADDR_STRAP:   reg_rdata_o <= strap_cap[15:0];
        scd_pkg::ADDR_STATUS:
          reg_rdata_o <= {14'h0000, rsvd_misuse, state == SCD_RUN};
        default:               reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  property p_load_once;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state == SCD_RUN) |=> (state == SCD_RUN);
  endproperty
  a_load_once: assert property (p_load_once) else $error("reload");

  property p_downshift;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ld |=> reg_ext[scd_pkg::DOWNSHIFT_BIT] == $past(strap_sync[30]);
  endproperty
  a_downshift: assert property (p_downshift) else $error("downshift");

  property p_speed10;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ld && spd == 2'b10) |=> (reg_gig[9:8] == 2'b10 && reg_adv[8:5] == 4'h0);
  endproperty
  a_speed10: assert property (p_speed10) else $error("speed 10");

  property p_speed00;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ld && spd == 2'b00) |=> (reg_gig[9:8] == 2'b11 && reg_adv[8:5] == 4'hF);
  endproperty
  a_speed00: assert property (p_speed00) else $error("speed 00");

  property p_speed11;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ld && spd == 2'b11) |=> (reg_gig[9:8] == 2'b00 && reg_adv[8:5] == 4'hF);
  endproperty
  a_speed11: assert property (p_speed11) else $error("speed 11");

  sequence s_fill_then_load;
    (state == SCD_SETTLE) ##1 (state == SCD_FILL) ##1 ld;
  endsequence

  property p_load_walk;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(rst_b_i) |-> s_fill_then_load;
  endproperty
  a_load_walk: assert property (p_load_walk) else $error("walk");

  property p_pause;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ld |=> reg_adv[11:10] == $past(strap_sync[25:24]);
  endproperty
  a_pause: assert property (p_pause) else $error("pause");

  property p_media;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ld |=> ##1 media_sel_o == $past(media, 2);
  endproperty
  a_media: assert property (p_media) else $error("media");

  property p_aux_fast;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ld |=> ##1 aux_clock_output_fast_o == $past(strap_sync[21], 2);
  endproperty
  a_aux_fast: assert property (p_aux_fast) else $error("aux freq");

  property p_aux_en;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ld |=> ##1 aux_clock_output_en_o == $past(strap_sync[20], 2);
  endproperty
  a_aux_en: assert property (p_aux_en) else $error("aux enable");
endmodule : scd_strap_decoder
`default_nettype wire

/* File: testbench/scd_strap_board.sv */
// board model: strap resistors on the eight configuration pins
`timescale 1ns/1ns
`default_nettype none
module scd_strap_board (
  input  wire logic [31:0] strap_value_i,
  input  wire logic        break_rsvd_i,
  output logic      [31:0] config_strap_pins_o
);
  // resistor levels are static; reserved bits stay low unless told to break
  always_comb begin
    config_strap_pins_o = strap_value_i;
    if (!break_rsvd_i) begin
      config_strap_pins_o[31] = 1'b0;
      config_strap_pins_o[22] = 1'b0;
    end
  end
endmodule : scd_strap_board
`default_nettype wire

/* File: testbench/strap_pin_config_decoder_tb_top.sv */
// testbench: strap sampling, register defaults and register port checks
`timescale 1ns/1ns
`default_nettype none
module strap_pin_config_decoder_tb_top;
  logic        sys_clk_i;
  logic        rst_b_i;
  logic [31:0] pins;
  logic [31:0] strap_value;
  logic        break_rsvd;
  logic [31:0] saved;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        load_done;
  logic [2:0]  media_sel;
  logic        aux_en;
  logic        aux_fast;
  logic        downshift_en;
  logic        mac_aneg_en;
  logic        ldps;
  int          miscompares;
  int          tests_run;

  scd_strap_board i_board (
    .strap_value_i      (strap_value),
    .break_rsvd_i       (break_rsvd),
    .config_strap_pins_o(pins)
  );

  scd_strap_decoder i_dut (
    .sys_clk_i               (sys_clk_i),
    .rst_b_i                 (rst_b_i),
    .config_strap_pins_i     (pins),
    .reg_addr_i              (reg_addr),
    .reg_wdata_i             (reg_wdata),
    .reg_wr_i                (reg_wr),
    .reg_rd_i                (reg_rd),
    .reg_rdata_o             (reg_rdata),
    .load_done_o             (load_done),
    .media_sel_o             (media_sel),
    .aux_clock_output_en_o   (aux_en),
    .aux_clock_output_fast_o (aux_fast),
    .downshift_en_o          (downshift_en),
    .mac_aneg_en_o           (mac_aneg_en),
    .link_down_power_saving_o(ldps)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  function automatic logic [15:0] exp_reg(input logic [3:0] a,
                                          input logic [31:0] s);
    logic [5:0]  ab;
    logic [15:0] r;
    logic        mis;
    case (s[29:28])
      2'h0: ab = 6'h3F;
      2'h1: ab = 6'h3E;
      2'h2: ab = 6'h02;
      default: ab = 6'h3C;
    endcase
    mis = s[31] | s[22] | ({s[23], s[19], s[15]} == 3'h4);
    case (a)
      scd_pkg::ADDR_ADV: r = {4'h0, s[25], s[24], 1'b0, ab[5:2], 5'h00};
      scd_pkg::ADDR_GIG: r = {6'h00, ab[1:0], 8'h00};
      scd_pkg::ADDR_AUX_EN: r = {15'h0000, s[20]};
      scd_pkg::ADDR_EXT_CTL: r = {7'h00, s[21], 3'h0, s[30], 4'h0};
      scd_pkg::ADDR_MAC_CTL: r = {2'h0, s[27], 2'h0, s[23], s[19], s[15], 8'h00};
      scd_pkg::ADDR_PWR_CTL: r = {9'h000, s[26], 6'h00};
      scd_pkg::ADDR_STRAP: r = s[15:0];
      scd_pkg::ADDR_STATUS: r = {14'h0000, mis, 1'b1};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : exp_reg

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    reg_addr <= a;
    @(posedge sys_clk_i);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd_chk

  task automatic load_straps(input logic [31:0] v, input logic b);
    int n;
    @(posedge sys_clk_i);
    rst_b_i     <= 1'b0;
    strap_value <= v;
    break_rsvd  <= b;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    n = 0;
    // bounded wait for the one-time strap load after reset
    while (load_done !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (load_done !== 1'b1) begin
      miscompares++;
      $display("ERROR load_done expected 1 seen %b", load_done);
      report_and_stop();
    end
    chk("load_latency", 16'h0004, n[15:0]);
  endtask : load_straps

  initial begin
    logic [31:0] sv;
    sys_clk_i = 1'b0;
    rst_b_i = 1'b0;
    strap_value = 32'h00000000;
    break_rsvd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(32'hFAA0BA7A));
    // every speed code four times, every media code twice, one bad board
    for (int i = 0; i < 16; i++) begin
      sv = $urandom;
      sv[29:28] = i[1:0];
      {sv[23], sv[19], sv[15]} = i[2:0];
      load_straps(sv, i == 12);
      for (int a = 0; a < 9; a++) begin
        rd_chk(a[3:0], exp_reg(a[3:0], pins));
      end
      chk("field_outputs", {8'h00, pins[23], pins[19], pins[15], pins[20],
          pins[21], pins[30], pins[27], pins[26]}, {8'h00, media_sel, aux_en,
          aux_fast, downshift_en, mac_aneg_en, ldps});
    end
    // later strap changes and writes to read-only or unmapped places are ignored
    @(posedge sys_clk_i);
    saved = pins;
    strap_value <= ~strap_value;
    wr(scd_pkg::ADDR_STRAP, 16'hFFFF);
    rd_chk(scd_pkg::ADDR_STRAP, saved[15:0]);
    rd_chk(scd_pkg::ADDR_ADV, exp_reg(scd_pkg::ADDR_ADV, saved));
    wr(4'hF, 16'hFFFF);
    rd_chk(4'hF, 16'h0000);
    @(posedge sys_clk_i);
    #1;
    chk("rdata_idle", 16'h0000, reg_rdata);
    wr(scd_pkg::ADDR_EXT_CTL, 16'h0100);
    rd_chk(scd_pkg::ADDR_EXT_CTL, 16'h0100);
    chk("fast_downshift", 16'h0002, {14'h0000, aux_fast, downshift_en});
    wr(scd_pkg::ADDR_MAC_CTL, 16'h2400);
    rd_chk(scd_pkg::ADDR_MAC_CTL, 16'h2400);
    chk("mac_media", 16'h000C, {12'h000, mac_aneg_en, media_sel});
    report_and_stop();
  end
endmodule : strap_pin_config_decoder_tb_top
`default_nettype wire
